// file: hdl/sfl_pkg.sv
// Constants and types for the supply fault and current limit block
package sfl_pkg;
   // Clock and timing
   localparam int CLK_HZ          = 40_000_000;
   localparam int LINK_BAUD       = 9600;
   localparam int LINK_BIT_CYCLES = CLK_HZ / LINK_BAUD;
   localparam int SETTLE_NS       = 50_000;
   localparam int SETTLE_CYCLES   = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SETTLE_W        = $clog2(SETTLE_CYCLES + 1);
   localparam int BAUD_W          = 16;

   // Threshold code
   localparam int         THR_W     = 8;
   localparam logic [7:0] THR_RESET = 8'h40;

   // Register map (byte addresses)
   localparam int         ADDR_W     = 4;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_THRESH = 4'h4;
   localparam logic [3:0] REG_LINK   = 4'h8;

   // Link message codes
   localparam logic [7:0] MSG_SET_THRESH = 8'h81;

   // Status byte bit positions
   localparam int ST_W       = 8;
   localparam int ST_BUCK_OC = 0;
   localparam int ST_OUT_LOW = 1;
   localparam int ST_BROWN   = 2;
   localparam int ST_UV      = 3;
   localparam int ST_WARN    = 4;
   localparam int ST_OT      = 5;
   localparam int ST_OV32    = 6;
   localparam int ST_CMP     = 7;

   // Synchronised detector vector positions
   localparam int AN_W       = 13;
   localparam int AN_BUCK_OC = 0;
   localparam int AN_LT90    = 1;
   localparam int AN_GE94    = 2;
   localparam int AN_LT80    = 3;
   localparam int AN_OVSTOP  = 4;
   localparam int AN_UVSTOP  = 5;
   localparam int AN_PUMP    = 6;
   localparam int AN_LT5V5   = 7;
   localparam int AN_GT32    = 8;
   localparam int AN_OTSHUT  = 9;
   localparam int AN_HYST    = 10;
   localparam int AN_WARN    = 11;
   localparam int AN_ISENSE  = 12;

   // Link receiver states
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sfl_rx_state_type;
endpackage : sfl_pkg

// file: hdl/sfl_supervisor.sv
// Supply supervisor, fault latches, threshold code and status link
`timescale 1ns/1ps
// Operation
// R1: Buck peak current over limit sets overcurrent status and sends a message.
// R2: Buck overcurrent status clears itself when current falls below limit.
// R3: Buck output under 90 percent sets output-low status and sends message.
// R4: Output-low status clears only once output recovers to 94 percent.
// R5: Buck output under 80 percent shuts the system down as brown-out.
// R6: Supply above overvoltage stop level turns buck regulator off.
// R7: Supply below undervoltage stop level turns buck regulator off.
// R8: Charge pump on only while supply is below pump start level.
// R9: Supply undervoltage stops motor drivers, keeps bias and link, reports status.
// R10: Extreme supply overvoltage turns every function off.
// R11: Overtemperature turns every function off.
// R12: Overtemperature releases only when cooled and chip enable toggled.
// R13: Warning message is sent before overtemperature shutdown is reached.
// R14: Host sets 8-bit threshold code with a threshold-set message.
// R15: Threshold code maps linearly to comparator reference from zero offset.
// R16: Threshold code loads its default at power-up.
// R17: Reference counts as settled only 50 us after a new code.
// R18: Phase-one sense above reference raises the overcurrent flag.
// R19: Comparator result is ORed with driver fault onto the flag output.
// R20: Comparator trip never disables motor drivers; host acts on flag.
// R21: Only one current limit comparator exists.
// R22: Latched fault clears at chip enable rise if condition is gone.
// R23: Open-drain flag pulled low during trip and during motor fault.
// R24: Chip enable low stops bridge, sense amps, 12 V regulator only.
// R25: Messages use half-duplex open-drain link, 8 data bits, no parity.
// R26: Detector results pass two flip-flops before use.
// R27: Every status change is queued and sent in order when link idle. The code drops a change while the QDEPTH-entry queue is full and sets q_drop.
module sfl_supervisor #(
   parameter int BIT_CYCLES = sfl_pkg::LINK_BIT_CYCLES,
   parameter int QDEPTH     = 4
) (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic [sfl_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   output logic      [31:0]                avs_readdata,
   output logic                            avs_waitrequest,
   input  wire logic                       buck_oc_raw,
   input  wire logic                       buck_lt90_raw,
   input  wire logic                       buck_ge94_raw,
   input  wire logic                       buck_lt80_raw,
   input  wire logic                       vdd_gt_ovstop_raw,
   input  wire logic                       vdd_lt_uvstop_raw,
   input  wire logic                       vdd_lt_pump_raw,
   input  wire logic                       vdd_lt_5v5_raw,
   input  wire logic                       vdd_gt_32v_raw,
   input  wire logic                       temp_gt_shut_raw,
   input  wire logic                       temp_lt_hyst_raw,
   input  wire logic                       temp_warn_raw,
   input  wire logic                       isense1_gt_ref_raw,
   input  wire logic                       driver_fault,
   input  wire logic                       chip_enable,
   input  wire logic                       supervisor_link_pin_i,
   output logic                            supervisor_link_pin_o,
   output logic                            supervisor_link_pin_oe,
   output logic                            overcurrent_flag_out_o,
   output logic                            overcurrent_flag_out_oe,
   output logic      [sfl_pkg::THR_W-1:0]  threshold_code,
   output logic                            threshold_settled,
   output logic                            buck_enable,
   output logic                            pump_enable,
   output logic                            core_enable,
   output logic                            driver_enable,
   output logic                            sense_amp_enable,
   output logic                            ldo12_enable
);
   import sfl_pkg::*;

   localparam int QW = $clog2(QDEPTH);

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction : reg_hit

   logic [AN_W-1:0]   raw;
   logic [AN_W-1:0]   sy1;
   logic [AN_W-1:0]   sy2;
   logic              ce_q;
   logic              ce_rise;
   logic              out_low;
   logic              brown;
   logic              ot_latch;
   logic              sys_down;
   logic [ST_W-1:0]   status;
   logic [ST_W-1:0]   status_q;
   logic              wr_take;
   logic              thr_load_bus;
   logic              thr_load_link;
   logic              thr_load;
   logic [THR_W-1:0]  next_code;
   logic [SETTLE_W-1:0] settle_cnt;
   logic [31:0]       rd_mux;
   logic              q_push;
   logic              q_pop;
   logic              q_full;
   logic              q_empty;
   logic              q_drop;
   logic [ST_W-1:0]   q_mem [QDEPTH];
   logic [QW-1:0]     q_wp;
   logic [QW-1:0]     q_rp;
   logic [QW:0]       q_cnt;
   sfl_rx_state_type  rx_st;
   logic [BAUD_W-1:0] rx_cnt;
   logic [2:0]        rx_bits;
   logic [7:0]        rx_sh;
   logic              rx_done;
   logic              rx_armed;
   logic              tx_busy;
   logic [9:0]        tx_sh;
   logic [3:0]        tx_bits;
   logic [BAUD_W-1:0] tx_cnt;
   logic              tx_start;

   // Detector vector
   assign raw = {isense1_gt_ref_raw, temp_warn_raw, temp_lt_hyst_raw, temp_gt_shut_raw, vdd_gt_32v_raw,
                 vdd_lt_5v5_raw, vdd_lt_pump_raw, vdd_lt_uvstop_raw, vdd_gt_ovstop_raw, buck_lt80_raw,
                 buck_ge94_raw, buck_lt90_raw, buck_oc_raw};

   // Two-stage synchronisers
   genvar g;
   generate
      for (g = 0; g < AN_W; g++) begin : g_sync
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               sy1[g] <= 1'b0;
               sy2[g] <= 1'b0;
            end else begin
               sy1[g] <= raw[g]; // R26
               sy2[g] <= sy1[g]; // R26
            end
         end
      end
   endgenerate

   // Fault release and shutdown decode
   assign ce_rise  = chip_enable & ~ce_q;
   assign sys_down = brown | ot_latch | sy2[AN_GT32]; // R5 R10 R11

   // Status byte
   assign status = {sy2[AN_ISENSE], sy2[AN_GT32], ot_latch, sy2[AN_WARN], // R13
                    sy2[AN_LT5V5], brown, out_low, sy2[AN_BUCK_OC]};      // R1 R2 R9

   // Fault latches and hysteresis
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ce_q     <= 1'b0;
         out_low  <= 1'b0;
         brown    <= 1'b0;
         ot_latch <= 1'b0;
         status_q <= '0;
      end else begin
         ce_q     <= chip_enable;
         status_q <= status;
         if (sy2[AN_LT90])
            out_low <= 1'b1; // R3
         else if (sy2[AN_GE94])
            out_low <= 1'b0; // R4
         if (sy2[AN_LT80])
            brown <= 1'b1; // R5
         else if (ce_rise)
            brown <= 1'b0; // R22
         if (sy2[AN_OTSHUT])
            ot_latch <= 1'b1; // R11
         else if (ce_rise && sy2[AN_HYST])
            ot_latch <= 1'b0; // R12
      end
   end

   // Power and function enables
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         buck_enable      <= 1'b0;
         pump_enable      <= 1'b0;
         core_enable      <= 1'b0;
         driver_enable    <= 1'b0;
         sense_amp_enable <= 1'b0;
         ldo12_enable     <= 1'b0;
      end else begin
         buck_enable      <= ~(sy2[AN_OVSTOP] | sy2[AN_UVSTOP] | sy2[AN_GT32] | ot_latch); // R6 R7
         pump_enable      <= sy2[AN_PUMP] & ~sys_down;                                      // R8
         core_enable      <= ~sys_down;
         driver_enable    <= chip_enable & ~sys_down & ~sy2[AN_LT5V5];                      // R9 R20 R24
         sense_amp_enable <= chip_enable & ~sys_down;                                       // R24
         ldo12_enable     <= chip_enable & ~sys_down;                                       // R24
      end
   end

   // Open-drain overcurrent flag from the single comparator ORed with driver fault
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         overcurrent_flag_out_o  <= 1'b0;
         overcurrent_flag_out_oe <= 1'b0;
      end else begin
         overcurrent_flag_out_o  <= 1'b0;
         overcurrent_flag_out_oe <= sy2[AN_ISENSE] | driver_fault; // R18 R19 R21 R23
      end
   end

   // Register bus decode
   assign wr_take      = avs_write & ~avs_waitrequest;
   assign thr_load_bus = wr_take & reg_hit(avs_address, REG_THRESH);
   assign thr_load     = thr_load_bus | thr_load_link;
   assign next_code    = thr_load_link ? rx_sh : avs_writedata[THR_W-1:0];
   assign rd_mux = reg_hit(avs_address, REG_STATUS) ? {24'h000000, status} :
                   reg_hit(avs_address, REG_THRESH) ? {23'h000000, threshold_settled, threshold_code} :
                   reg_hit(avs_address, REG_LINK)   ? {26'h0000000, q_drop, tx_busy, q_full, q_empty,
                                                        (rx_st != RX_IDLE), rx_armed} : 32'h00000000;

   // Bus slave, one wait cycle per access
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else if ((avs_read | avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= rd_mux;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Threshold code and settle timer
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         threshold_code    <= THR_RESET; // R16
         settle_cnt        <= SETTLE_W'(SETTLE_CYCLES);
         threshold_settled <= 1'b0;
      end else if (thr_load) begin
         threshold_code    <= next_code; // R14 R15
         settle_cnt        <= SETTLE_W'(SETTLE_CYCLES); // R17
         threshold_settled <= 1'b0;
      end else begin
         if (settle_cnt != '0)
            settle_cnt <= settle_cnt - 1'b1;
         threshold_settled <= (settle_cnt == '0); // R17
      end
   end

   // Status message queue
   assign q_full  = (q_cnt == (QW+1)'(QDEPTH));
   assign q_empty = (q_cnt == '0);
   assign q_push  = (status != status_q); // R27
   assign q_pop   = tx_start;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         q_wp   <= '0;
         q_rp   <= '0;
         q_cnt  <= '0;
         q_drop <= 1'b0;
      end else begin
         if (q_push && !q_full) begin
            q_mem[q_wp] <= status; // R27
            q_wp        <= (q_wp == QW'(QDEPTH-1)) ? '0 : q_wp + 1'b1;
         end
         if (q_push && q_full)
            q_drop <= 1'b1;
         if (q_pop)
            q_rp <= (q_rp == QW'(QDEPTH-1)) ? '0 : q_rp + 1'b1;
         q_cnt <= q_cnt + (QW+1)'(q_push && !q_full) - (QW+1)'(q_pop);
      end
   end

   // Link receiver, 8 data bits, no parity
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rx_st   <= RX_IDLE;
         rx_cnt  <= '0;
         rx_bits <= 3'h0;
         rx_sh   <= 8'h00;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         case (rx_st)
            RX_IDLE: begin
               if (!supervisor_link_pin_i && !tx_busy) begin // R25
                  rx_st  <= RX_START;
                  rx_cnt <= BAUD_W'(BIT_CYCLES / 2);
               end
            end
            RX_START: begin
               if (rx_cnt != '0)
                  rx_cnt <= rx_cnt - 1'b1;
               else if (!supervisor_link_pin_i) begin
                  rx_st   <= RX_DATA;
                  rx_cnt  <= BAUD_W'(BIT_CYCLES - 1);
                  rx_bits <= 3'h0;
               end else
                  rx_st <= RX_IDLE;
            end
            RX_DATA: begin
               if (rx_cnt != '0)
                  rx_cnt <= rx_cnt - 1'b1;
               else begin
                  rx_sh   <= {supervisor_link_pin_i, rx_sh[7:1]};
                  rx_cnt  <= BAUD_W'(BIT_CYCLES - 1);
                  rx_bits <= rx_bits + 1'b1;
                  if (rx_bits == 3'h7)
                     rx_st <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_cnt != '0)
                  rx_cnt <= rx_cnt - 1'b1;
               else begin
                  rx_st   <= RX_IDLE;
                  rx_done <= supervisor_link_pin_i;
               end
            end
            default: rx_st <= RX_IDLE;
         endcase
      end
   end

   // Threshold-set message: command byte then code byte
   assign thr_load_link = rx_done & rx_armed; // R14
   always_ff @(posedge clk) begin
      if (!rst_b)
         rx_armed <= 1'b0;
      else if (rx_done)
         rx_armed <= ~rx_armed & (rx_sh == MSG_SET_THRESH);
   end

   // Link transmitter, only while the line is idle
   assign tx_start = ~tx_busy & ~q_empty & (rx_st == RX_IDLE) & supervisor_link_pin_i; // R25 R27
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tx_busy                <= 1'b0;
         tx_sh                  <= 10'h3ff;
         tx_bits                <= 4'h0;
         tx_cnt                 <= '0;
         supervisor_link_pin_o  <= 1'b0;
         supervisor_link_pin_oe <= 1'b0;
      end else begin
         supervisor_link_pin_o <= 1'b0;
         if (tx_start) begin
            tx_busy                <= 1'b1;
            tx_sh                  <= {1'b1, q_mem[q_rp], 1'b0};
            tx_bits                <= 4'h0;
            tx_cnt                 <= BAUD_W'(BIT_CYCLES - 1);
            supervisor_link_pin_oe <= 1'b1;
         end else if (tx_busy) begin
            if (tx_cnt != '0)
               tx_cnt <= tx_cnt - 1'b1;
            else if (tx_bits == 4'h9) begin
               tx_busy                <= 1'b0;
               supervisor_link_pin_oe <= 1'b0;
            end else begin
               tx_sh                  <= {1'b1, tx_sh[9:1]};
               tx_bits                <= tx_bits + 1'b1;
               tx_cnt                 <= BAUD_W'(BIT_CYCLES - 1);
               supervisor_link_pin_oe <= ~tx_sh[1];
            end
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_oc_high;
      !buck_oc_raw ##1 buck_oc_raw [*3];
   endsequence
   sequence s_oc_low;
      !buck_oc_raw [*3];
   endsequence

   property p_buck_oc_set;
      s_oc_high |-> status[ST_BUCK_OC] ##1 q_cnt != '0 || q_drop;
   endproperty
   a_buck_oc_set: assert property (p_buck_oc_set) else $error("buck overcurrent not reported"); // R1
   property p_buck_oc_clr;
      s_oc_low |-> !status[ST_BUCK_OC];
   endproperty
   a_buck_oc_clr: assert property (p_buck_oc_clr) else $error("buck overcurrent did not clear"); // R2
   property p_out_low_hold;
      out_low && !sy2[AN_GE94] |=> out_low;
   endproperty
   a_out_low_hold: assert property (p_out_low_hold) else $error("output-low cleared early"); // R4
   property p_ovstop;
      vdd_gt_ovstop_raw [*3] |=> !buck_enable;
   endproperty
   a_ovstop: assert property (p_ovstop) else $error("buck on above overvoltage stop"); // R6
   property p_pump;
      !vdd_lt_pump_raw [*3] |=> !pump_enable;
   endproperty
   a_pump: assert property (p_pump) else $error("pump on above start level"); // R8
   property p_ot_hold;
      ot_latch && !ce_rise |=> ot_latch;
   endproperty
   a_ot_hold: assert property (p_ot_hold) else $error("overtemperature released without enable rise"); // R12
   property p_trip_no_stop;
      chip_enable && core_enable && !sys_down && !sy2[AN_LT5V5] |=> driver_enable;
   endproperty
   a_trip_no_stop: assert property (p_trip_no_stop) else $error("drivers off without cause"); // R20
   property p_settle;
      thr_load |=> !threshold_settled [*8];
   endproperty
   a_settle: assert property (p_settle) else $error("reference settled too early"); // R17
   property p_flag;
      isense1_gt_ref_raw [*3] |=> overcurrent_flag_out_oe && !overcurrent_flag_out_o;
   endproperty
   a_flag: assert property (p_flag) else $error("overcurrent flag not pulled low"); // R19
endmodule : sfl_supervisor

// file: verif/sfl_host_model.sv
// Host model: open-drain link partner that sends commands and logs status bytes
`timescale 1ns/1ps
module sfl_host_model #(
   parameter int BIT_CYCLES = 16
) (
   input  wire logic clk,
   input  wire logic line,
   output logic      host_oe
);
   logic [7:0] rxq[$];
   int         bad;
   logic [7:0] sh;

   // Receiver: waits half a bit after the falling edge without rechecking start, LSB first, stop must be high
   initial begin
      host_oe = 1'b0;
      bad = 0;
      forever begin
         @(posedge clk);
         if (line === 1'b0 && host_oe === 1'b0) begin
            repeat (BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CYCLES) @(posedge clk);
               sh[i] = line;
            end
            repeat (BIT_CYCLES) @(posedge clk);
            if (line !== 1'b1)
               bad++;
            else
               rxq.push_back(sh);
         end
      end
   end

   // Sender: one start, eight data LSB first, one stop; line released for ones
   task automatic send(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         host_oe <= ~fr[i];
         repeat (BIT_CYCLES) @(posedge clk);
      end
   endtask : send
endmodule : sfl_host_model

// file: verif/tb.sv
// Self-checking testbench for the supply supervisor block
`timescale 1ns/1ps
module tb;
   import sfl_pkg::*;
   localparam int BC = 16;
   logic        clk, rst_b, avs_read, avs_write, driver_fault, chip_enable;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        avs_waitrequest, link_o, link_oe, flag_o, flag_oe, settled, host_oe;
   logic [12:0] raw;
   logic [7:0]  code;
   logic [5:0]  en;
   wire         link;
   int          failures, n_tests;

   // Pulled-up open-drain line
   assign link = ~(link_oe | host_oe);

   sfl_supervisor #(.BIT_CYCLES(BC)) dut (
      .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .buck_oc_raw(raw[AN_BUCK_OC]), .buck_lt90_raw(raw[AN_LT90]), .buck_ge94_raw(raw[AN_GE94]),
      .buck_lt80_raw(raw[AN_LT80]), .vdd_gt_ovstop_raw(raw[AN_OVSTOP]), .vdd_lt_uvstop_raw(raw[AN_UVSTOP]),
      .vdd_lt_pump_raw(raw[AN_PUMP]), .vdd_lt_5v5_raw(raw[AN_LT5V5]), .vdd_gt_32v_raw(raw[AN_GT32]),
      .temp_gt_shut_raw(raw[AN_OTSHUT]), .temp_lt_hyst_raw(raw[AN_HYST]), .temp_warn_raw(raw[AN_WARN]),
      .isense1_gt_ref_raw(raw[AN_ISENSE]), .driver_fault(driver_fault), .chip_enable(chip_enable),
      .supervisor_link_pin_i(link), .supervisor_link_pin_o(link_o), .supervisor_link_pin_oe(link_oe),
      .overcurrent_flag_out_o(flag_o), .overcurrent_flag_out_oe(flag_oe), .threshold_code(code),
      .threshold_settled(settled), .buck_enable(en[5]), .pump_enable(en[4]), .core_enable(en[3]),
      .driver_enable(en[2]), .sense_amp_enable(en[1]), .ldo12_enable(en[0]));

   sfl_host_model #(.BIT_CYCLES(BC)) host (.clk(clk), .line(link), .host_oe(host_oe));

   // Clock at 25 ns period
   always #12.5 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // One bus access held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (n >= 50)
         chk(32'h1, 32'h0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   // Let the link drain, then forget what arrived
   task automatic flush;
      tick(800);
      host.rxq.delete();
   endtask : flush

   task automatic msg(input logic [7:0] e);
      int n;
      n = 0;
      while (host.rxq.size() == 0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk(host.rxq.size() ? host.rxq.pop_front() : 9'h100, e);
   endtask : msg

   task automatic ce_toggle;
      chip_enable <= 1'b0;
      tick(6);
      chip_enable <= 1'b1;
      tick(6);
   endtask : ce_toggle

   task automatic t_thr;
      int n;
      chk(code, 8'h40);
      chk(settled, 1'b0);
      tick(2100);
      rd(REG_THRESH, 32'h140);
      chk(en, 6'b101111);
      host.send(MSG_SET_THRESH);
      host.send(8'hff);
      n = 0;
      while (code !== 8'hff && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk(code, 8'hff);
      chk(settled, 1'b0);
      tick(1990);
      chk(settled, 1'b0);
      tick(20);
      chk(settled, 1'b1);
      host.send(8'h55);
      host.send(8'h22);
      tick(40);
      chk(code, 8'hff);
      rd(REG_LINK, 32'h4);
      wr(REG_THRESH, 32'h0);
      tick(1);
      chk(code, 8'h00);
      wr(REG_STATUS, 32'hff);
      rd(REG_STATUS, 32'h0);
      rd(4'hc, 32'h0);
      $display("threshold test done");
   endtask : t_thr

   // Raise one detector, expect its status bit, enables and two messages in order
   task automatic st_case(input int a, input int s, input logic [5:0] e);
      flush();
      raw[a] <= 1'b1;
      tick(6);
      rd(REG_STATUS, 32'h1 << s);
      chk(en, e);
      msg(8'h1 << s);
      raw[a] <= 1'b0;
      tick(6);
      rd(REG_STATUS, 32'h0);
      msg(8'h0);
   endtask : st_case

   task automatic t_status;
      st_case(AN_BUCK_OC, ST_BUCK_OC, 6'b101111);
      st_case(AN_LT5V5, ST_UV, 6'b101011);
      st_case(AN_WARN, ST_WARN, 6'b101111);
      $display("status test done");
   endtask : t_status

   task automatic t_hyst;
      flush();
      raw[AN_LT90] <= 1'b1;
      raw[AN_GE94] <= 1'b0;
      tick(6);
      rd(REG_STATUS, 32'h2);
      msg(8'h02);
      raw[AN_LT90] <= 1'b0;
      tick(6);
      rd(REG_STATUS, 32'h2);
      raw[AN_GE94] <= 1'b1;
      tick(6);
      rd(REG_STATUS, 32'h0);
      msg(8'h00);
      $display("hysteresis test done");
   endtask : t_hyst

   task automatic t_supply;
      int         an[4];
      logic [5:0] ex[4];
      an = '{AN_OVSTOP, AN_UVSTOP, AN_PUMP, AN_GT32};
      ex = '{6'b001111, 6'b001111, 6'b111111, 6'b000000};
      for (int i = 0; i < 4; i++) begin
         raw[an[i]] <= 1'b1;
         tick(6);
         chk(en, ex[i]);
         raw[an[i]] <= 1'b0;
         tick(6);
         chk(en, 6'b101111);
      end
      $display("supply test done");
   endtask : t_supply

   task automatic t_cmp;
      raw[AN_ISENSE] <= 1'b1;
      tick(6);
      chk(flag_oe, 1'b1);
      chk(en, 6'b101111);
      rd(REG_STATUS, 32'h80);
      raw[AN_ISENSE] <= 1'b0;
      driver_fault <= 1'b1;
      tick(6);
      chk(flag_oe, 1'b1);
      driver_fault <= 1'b0;
      tick(6);
      chk({flag_oe, flag_o}, 2'b00);
      $display("comparator test done");
   endtask : t_cmp

   task automatic t_ce;
      chip_enable <= 1'b0;
      tick(6);
      chk(en, 6'b101000);
      chip_enable <= 1'b1;
      tick(6);
      chk(en, 6'b101111);
      $display("chip enable test done");
   endtask : t_ce

   task automatic t_brown;
      raw[AN_LT80] <= 1'b1;
      tick(6);
      chk(en, 6'b100000);
      rd(REG_STATUS, 32'h4);
      raw[AN_LT80] <= 1'b0;
      tick(6);
      chk(en, 6'b100000);
      ce_toggle();
      chk(en, 6'b101111);
      $display("brownout test done");
   endtask : t_brown

   task automatic t_ot;
      raw[AN_OTSHUT] <= 1'b1;
      raw[AN_HYST] <= 1'b0;
      tick(6);
      chk(en, 6'b000000);
      rd(REG_STATUS, 32'h20);
      raw[AN_OTSHUT] <= 1'b0;
      tick(6);
      ce_toggle();
      chk(en, 6'b000000);
      raw[AN_HYST] <= 1'b1;
      tick(6);
      chk(en, 6'b000000);
      ce_toggle();
      chk(en, 6'b101111);
      $display("overtemperature test done");
   endtask : t_ot

   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      results();
   end

   // Main sequence
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      driver_fault = 1'b0;
      chip_enable = 1'b1;
      raw = 13'h0;
      raw[AN_GE94] = 1'b1;
      raw[AN_HYST] = 1'b1;
      failures = 0;
      n_tests = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_thr();
      t_status();
      t_hyst();
      t_supply();
      t_cmp();
      t_ce();
      t_brown();
      t_ot();
      chk(host.bad, 0);
      chk(link_o, 1'b0);
      results();
   end
endmodule : tb
